// ---- hdl/psrc_bank.sv ----
// pad slew rate control bank: ten masked-write slew registers, one per
// eight-pin group, driving the pad edge-rate controls.
// assumes one 125 MHz clock, synchronous reset, classic wishbone master.
//
// How it works
// - on a write, data bit n+16 permits the update of slew bit n.
// - a slew bit whose permission bit is written zero keeps its value.
// - the permission byte is write-only, reads zero, stores nothing.
// - bits 15 to 8 are reserved, read zero and ignore writes.
// - a slew bit of zero selects slow edges and one fast, driven to the pad.
// - every slew bit is read/write and resets to zero, i.e. slow.
// - slew bit k of a register controls pin k of its group.
// - registers sit at word offsets for bank1 b-d, bank2 a-c, bank3 a-c.
// - bank1 group a sits one word below bank1 group b.

`timescale 1ns/1ps
`default_nettype none

module psrc_bank #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pad edge-rate controls, 1 = fast
  output logic [7:0] bank1_grp_a_edge_rate_o,
  output logic [7:0] bank1_grp_b_edge_rate_o,
  output logic [7:0] bank1_grp_c_edge_rate_o,
  output logic [7:0] bank1_grp_d_edge_rate_o,
  output logic [7:0] bank2_grp_a_edge_rate_o,
  output logic [7:0] bank2_grp_b_edge_rate_o,
  output logic [7:0] bank2_grp_c_edge_rate_o,
  output logic [7:0] bank3_grp_a_edge_rate_o,
  output logic [7:0] bank3_grp_b_edge_rate_o,
  output logic [7:0] bank3_grp_c_edge_rate_o
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam int unsigned N = psrc_pkg::PSRC_NUM_REGS;
  localparam logic [7:0] OFFS [N] = '{
    psrc_pkg::PSRC_OFF_B1A, psrc_pkg::PSRC_OFF_B1B,
    psrc_pkg::PSRC_OFF_B1C, psrc_pkg::PSRC_OFF_B1D,
    psrc_pkg::PSRC_OFF_B2A, psrc_pkg::PSRC_OFF_B2B,
    psrc_pkg::PSRC_OFF_B2C, psrc_pkg::PSRC_OFF_B3A,
    psrc_pkg::PSRC_OFF_B3B, psrc_pkg::PSRC_OFF_B3C
  };

  logic [7:0] slew_q [N];
  logic [N-1:0] hit;
  logic ack_q;
  logic [31:0] dat_q;
  wire logic req = cyc_i && stb_i && !ack_q;
  wire logic [7:0] adr8 = 8'(adr_i);
  // byte lanes: lane 0 carries slew data, lane 2 the permissions
  wire logic [7:0] perm = dat_i[psrc_pkg::PSRC_PERM_LSB +: 8] &
    {8{sel_i[2]}};
  wire logic [7:0] wdat = dat_i[7:0] & {8{sel_i[0]}};

  // ---------------------------------------------------------------
  // per-register storage, one generate loop
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_reg
      // word-aligned match; bank2 group d slot is simply absent
      assign hit[g] = (adr8[7:2] == OFFS[g][7:2]);
      // masked write: only permitted bits move, others hold
      wire logic wr = req && we_i && hit[g];
      wire logic [7:0] nxt = (slew_q[g] & ~perm) | (wdat & perm);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          slew_q[g] <= psrc_pkg::PSRC_SLEW_RESET;
        end else if (wr) begin
          slew_q[g] <= nxt;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux: permissions never stored, reserved bits zero
  // ---------------------------------------------------------------
  logic [7:0] rd_slew;
  always_comb begin
    rd_slew = 8'h00;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        rd_slew = slew_q[i];
      end
    end
  end
  wire logic [31:0] rd_word = {24'h000000, rd_slew};

  // ack one cycle after request; unmapped reads return zero, writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= psrc_pkg::PSRC_UNMAPPED_DATA;
    end else begin
      ack_q <= req;
      if (req && !we_i) begin
        dat_q <= rd_word;
      end
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ---------------------------------------------------------------
  // pad outputs straight from storage (bit k = pin k)
  // ---------------------------------------------------------------
  assign bank1_grp_a_edge_rate_o = slew_q[0];
  assign bank1_grp_b_edge_rate_o = slew_q[1];
  assign bank1_grp_c_edge_rate_o = slew_q[2];
  assign bank1_grp_d_edge_rate_o = slew_q[3];
  assign bank2_grp_a_edge_rate_o = slew_q[4];
  assign bank2_grp_b_edge_rate_o = slew_q[5];
  assign bank2_grp_c_edge_rate_o = slew_q[6];
  assign bank3_grp_a_edge_rate_o = slew_q[7];
  assign bank3_grp_b_edge_rate_o = slew_q[8];
  assign bank3_grp_c_edge_rate_o = slew_q[9];

endmodule : psrc_bank

`default_nettype wire

// ---- hdl/psrc_pkg.sv ----
// package for the pad slew rate control bank: offsets, field layout,
// reset values. assumes a 32-bit classic wishbone register bus.

package psrc_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam int unsigned PSRC_NUM_REGS = 10;
  localparam logic [7:0] PSRC_OFF_B1A = 8'h90;
  localparam logic [7:0] PSRC_OFF_B1B = 8'h94;
  localparam logic [7:0] PSRC_OFF_B1C = 8'h98;
  localparam logic [7:0] PSRC_OFF_B1D = 8'h9c;
  localparam logic [7:0] PSRC_OFF_B2A = 8'ha0;
  localparam logic [7:0] PSRC_OFF_B2B = 8'ha4;
  localparam logic [7:0] PSRC_OFF_B2C = 8'ha8;
  localparam logic [7:0] PSRC_OFF_B3A = 8'hb0;
  localparam logic [7:0] PSRC_OFF_B3B = 8'hb4;
  localparam logic [7:0] PSRC_OFF_B3C = 8'hb8;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned PSRC_PERM_LSB = 16;
  localparam int unsigned PSRC_PINS = 8;
  localparam logic [7:0] PSRC_SLEW_RESET = 8'h00;
  localparam logic [31:0] PSRC_UNMAPPED_DATA = 32'h0000_0000;

endpackage : psrc_pkg

// ---- verif/psrc_bank_sva.sv ----
// checker: bus answer timing, masked writes, read layout
// assumes it is bound into psrc_bank by port names
`timescale 1ns/1ps
`default_nettype none
module psrc_bank_sva #(parameter int unsigned ADDR_W = 8) (
  // bus and pads
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic [7:0] bank1_grp_a_edge_rate_o,
  input wire logic [7:0] bank1_grp_b_edge_rate_o
);
  // one domain, so one default clock and reset
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [7:0] pa = bank1_grp_a_edge_rate_o;
  wire logic [7:0] pb = bank1_grp_b_edge_rate_o;
  wire logic rd = ack_o & !we_i;
  wire logic wr = ack_o & we_i;
  ack_once_a: assert property (cyc_i & stb_i & !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not one pulse one cycle on");
  rd_upper_a: assert property (rd |-> dat_o[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  rd_grp_b_a: assert property (rd && adr_i == 8'h94 |-> dat_o[7:0] == pb)
    else $error("group b read differs from pads");
  rd_grp_a_a: assert property (rd && adr_i == 8'h90 |-> dat_o[7:0] == pa)
    else $error("group a read differs from pads");
  rd_hole_a: assert property (rd && adr_i == 8'hac |-> dat_o == 32'h0)
    else $error("hole read not zero");
  wr_mask_a: assert property (wr && adr_i == 8'h94 && sel_i == 4'hf |->
    pb == ($past(pb) & ~dat_i[23:16] | dat_i[7:0] & dat_i[23:16]))
    else $error("masked write result wrong");
  hold_b_a: assert property ($changed(pb) |-> wr && adr_i == 8'h94)
    else $error("group b pads moved without a write");
  hold_a_a: assert property ($changed(pa) |-> wr && adr_i == 8'h90)
    else $error("group a pads moved without a write");
  rst_low_a: assert property ($past(rst_i) |-> (pa | pb) == 8'h0 && !ack_o)
    else $error("pads or ack not low after reset");
endmodule : psrc_bank_sva
bind psrc_bank psrc_bank_sva #(.ADDR_W(ADDR_W)) i_sva (.*);
`default_nettype wire

// ---- verif/psrc_bank_test.sv ----
// bench: wishbone reads and writes against the slew bank
// assumes psrc_bank and its bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module psrc_bank_test;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [7:0] adr_i = 8'h0, p, e [10];
  logic [7:0] offs [10] = '{8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4,
    8'ha8, 8'hb0, 8'hb4, 8'hb8};
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'hf;
  int errors = 0, total_checks = 0;
  psrc_bank i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o,
    .bank1_grp_a_edge_rate_o(e[0]), .bank1_grp_b_edge_rate_o(e[1]),
    .bank1_grp_c_edge_rate_o(e[2]), .bank1_grp_d_edge_rate_o(e[3]),
    .bank2_grp_a_edge_rate_o(e[4]), .bank2_grp_b_edge_rate_o(e[5]),
    .bank2_grp_c_edge_rate_o(e[6]), .bank3_grp_a_edge_rate_o(e[7]),
    .bank3_grp_b_edge_rate_o(e[8]), .bank3_grp_c_edge_rate_o(e[9]));
  task automatic chk(string n, logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // one classic cycle; the idle edge on entry keeps requests apart
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : bus
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial forever #4 clk_i = ~clk_i;
  // watchdog far beyond the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (offs[i]) begin
      bus(0, offs[i], 0);
      chk("reset read", rd, 0);
      chk("reset pad", e[i], 0);
    end
    $display("test reset done");
    // one-hot pattern per group, repeating after eight groups, reserved byte set, all permitted
    foreach (offs[i]) bus(1, offs[i], {16'h00ff, 8'hff, 8'h01 << (i % 8)});
    foreach (offs[i]) begin
      p = 8'h01 << (i % 8);
      bus(0, offs[i], 0);
      chk("group read", rd, {24'h0, p});
      chk("group pad", e[i], p);
    end
    $display("test map done");
    bus(1, 8'h94, 32'h0081_0080);
    chk("masked pad", e[1], 8'h82);
    // permission lane off: nothing may move even with data lane on
    sel_i <= 4'h1;
    bus(1, 8'h94, 32'h00ff_007f);
    sel_i <= 4'hf;
    chk("lane pad", e[1], 8'h82);
    bus(1, 8'hac, 32'hffff_ffff);
    bus(0, 8'hac, 0);
    chk("hole read", rd, 0);
    chk("hole pad", e[1], 8'h82);
    $display("test mask done");
    final_report();
  end
endmodule : psrc_bank_test
`default_nettype wire
